/* rtl/scc_pkg.sv */
package scc_pkg;
	// ==========================================
	// Widths
	localparam int SCC_DW = 8;
	localparam int SCC_CW = 7;
	localparam int SCC_AW = 2;

	// ==========================================
	// Register offsets
	localparam logic [1:0] SCC_ADDR_STATUS = 2'h0;
	localparam logic [1:0] SCC_ADDR_CONTROL = 2'h1;
	localparam logic [1:0] SCC_ADDR_MASK = 2'h2;
	localparam logic [1:0] SCC_ADDR_AUX = 2'h3;

	// ==========================================
	// Auxiliary control word fields and reset values
	localparam int SCC_AUX_W = 6;
	localparam int SCC_AUX_INT_EN = 4;
	localparam int SCC_AUX_RUN = 5;
	localparam int SCC_INT_BIT = 7;
	localparam logic [7:0] SCC_RST_STATUS = 8'h00;
	localparam logic [7:0] SCC_RST_CONTROL = 8'h00;
	localparam logic [6:0] SCC_RST_MASK = 7'h00;
	localparam logic [5:0] SCC_RST_AUX = 6'h00;
	localparam logic [6:0] SCC_TC_COUNT = 7'h00;

	// ==========================================
	// Modes
	typedef enum logic [1:0] {
		SCC_DIRECT = 2'b00,
		SCC_SYNC = 2'b01,
		SCC_DSYNC = 2'b10,
		SCC_PULSE = 2'b11
	} scc_ctl_mode_t;

	typedef enum logic [1:0] {
		SCC_OUT_CONTROL = 2'b00,
		SCC_OUT_COUNTER = 2'b01,
		SCC_OUT_PARALLEL = 2'b10,
		SCC_OUT_SPARE = 2'b11
	} scc_out_sel_t;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic sel;
		logic wr;
		logic rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} scc_bus_t;

	typedef struct packed {
		logic [7:0] status_bit_capture_select;
		logic [7:0] ctrl_bit_mode_high;
		logic [7:0] ctrl_bit_mode_low;
		logic routed_reset_scope;
		scc_out_sel_t sc_output_select;
		logic tc_comb;
		logic ld_indep;
		logic en_used;
		logic ld_used;
	} scc_cfg_t;
endpackage

/* rtl/scc_ctl_stage.sv */
`timescale 1ns/100ps
module scc_ctl_stage (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sc_tick_i,
	// Control bit
	input wire scc_pkg::scc_ctl_mode_t mode_i,
	input wire logic bit_i,
	input wire logic direct_i,
	input wire logic routed_reset_i,
	// Output
	output logic out_o,
	output logic pulse_done_o
);
	import scc_pkg::*;

	logic stage1;
	logic stage2;

	// ==========================================
	// Resampling registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= 1'b0;
		end else if (routed_reset_i) begin
			stage1 <= 1'b0;
		end else if (sc_tick_i) begin
			if (mode_i == SCC_PULSE) begin
				stage1 <= bit_i & ~stage1;
			end else begin
				stage1 <= bit_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage2 <= 1'b0;
		end else if (routed_reset_i) begin
			stage2 <= 1'b0;
		end else if (sc_tick_i) begin
			stage2 <= stage1;
		end
	end

	// Pulse ends at the tick closing its one full cycle
	assign pulse_done_o = (mode_i == SCC_PULSE) & sc_tick_i & stage1;

	always_comb begin
		unique case (mode_i)
			SCC_DIRECT: out_o = direct_i;
			SCC_SYNC: out_o = stage1;
			SCC_DSYNC: out_o = stage2;
			SCC_PULSE: out_o = stage1;
		endcase
	end

	// ==========================================
	// Checks
	a_pulse_one_cycle: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(sc_tick_i && mode_i == SCC_PULSE && stage1 && !routed_reset_i)
		|=> !stage1)
		else $error("pulse lasted more than one tick cycle");

	c_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_i == SCC_PULSE && pulse_done_o);
endmodule

/* rtl/scc_top.sv */
// Notes on behaviour
// - Eight-bit read-only status register from routing, zero after reset.
// - Per-bit select: zero reads live input, one captures highs, clears on read.
// - A clearing read clears only sticky bits that were set.
// - Sticky inputs sampled each status clock tick; highs held until cleared.
// - Status clear runs on the bus clock during the read, any mode.
// - Read data latched and held stable for the whole read access.
// - Interrupt is masked OR of low seven status bits; top bit reads it.
// - Eight-bit read/write control register driving routing, zero after reset.
// - Per-bit mode from high/low select: direct, synced, double, pulse.
// - Direct mode shows a control write on routing in the write cycle.
// - Synced mode resamples on status clock; double synced adds a stage.
// - Pulse mode outputs one full tick cycle after a write, then clears.
// - Pulse bit reads one until pulse ends; firmware waits before the next.
// - Routed reset clears output stage; scope one also clears control bit.
// - Counter mode: seven-bit down counter; count writable only when stopped.
// - At terminal count zero the period reloads into the count.
// - Run bit is the overriding enable; routed enable acts only under it.
// - Routed reload is level sensitive and beats terminal-count reload.
// - Count drives outputs 6:0, terminal count bit 7, registered or not.
// - By default reload needs the run bit and, if used, routed enable; alternately both independent.
// - Period N-1 divides by N; period zero gives constant terminal count.
// - Counter mode replaces control use and turns the mask into period.
`timescale 1ns/100ps
module scc_top (
	// Clock, reset and status clock enable
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sc_tick_i,
	// Register access
	input wire scc_pkg::scc_bus_t bus_i,
	output logic [7:0] bus_rdata_o,
	// Configuration
	input wire scc_pkg::scc_cfg_t cfg_i,
	// Routing inputs
	input wire logic [7:0] status_in_i,
	input wire logic [7:0] dp_parallel_out_i,
	input wire logic routed_enable_i,
	input wire logic routed_reload_i,
	input wire logic routed_reset_i,
	// Routing outputs
	output logic [7:0] sc_routing_output_o,
	output logic irq_o
);
	import scc_pkg::*;

	logic [7:0] status_capture;
	logic [7:0] control_output;
	logic [6:0] mask;
	logic [5:0] aux_control_word;
	logic [7:0] rdata;
	logic rd_q;
	logic tc_reg;

	logic counter_mode;
	logic rd_start;
	logic wr_ctl;
	logic wr_mask;
	logic wr_aux;
	logic stat_clr_rd;
	logic [7:0] stat_view;
	logic [7:0] stat_set;
	logic [7:0] stat_clr;
	logic [7:0] next_status;
	logic [7:0] pulse_done;
	logic [7:0] ctl_out;
	logic counter_run;
	logic int_en;
	logic en_eff;
	logic ld_eff;
	logic tc_comb;
	logic tc;
	logic [6:0] counter_value;
	logic [6:0] counter_period;
	logic [6:0] next_count;

	// ==========================================
	// Register access decode
	assign counter_mode = cfg_i.sc_output_select == SCC_OUT_COUNTER;
	assign rd_start = bus_i.sel & bus_i.rd & ~rd_q;
	assign wr_ctl = bus_i.sel & bus_i.wr & (bus_i.addr == SCC_ADDR_CONTROL);
	assign wr_mask = bus_i.sel & bus_i.wr & (bus_i.addr == SCC_ADDR_MASK);
	assign wr_aux = bus_i.sel & bus_i.wr & (bus_i.addr == SCC_ADDR_AUX);
	assign stat_clr_rd = rd_start & (bus_i.addr == SCC_ADDR_STATUS);
	assign counter_run = aux_control_word[SCC_AUX_RUN];
	assign int_en = aux_control_word[SCC_AUX_INT_EN];
	assign counter_value = control_output[6:0];
	assign counter_period = mask;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_q <= 1'b0;
		end else begin
			rd_q <= bus_i.sel & bus_i.rd;
		end
	end

	// ==========================================
	// Status capture
	// Only bits already set are cleared; a new sample in the same cycle wins
	assign stat_set = sc_tick_i ?
		(status_in_i & cfg_i.status_bit_capture_select) : 8'h00;
	assign stat_clr = stat_clr_rd ? status_capture : 8'h00;
	assign next_status = ((status_capture & ~stat_clr) | stat_set)
		& cfg_i.status_bit_capture_select;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_capture <= SCC_RST_STATUS;
		end else begin
			status_capture <= next_status;
		end
	end

	always_comb begin
		for (int i = 0; i < SCC_DW; i++) begin
			stat_view[i] = cfg_i.status_bit_capture_select[i] ?
				status_capture[i] : status_in_i[i];
		end
		// Interrupt unusable in counter mode since mask holds the period
		irq_o = int_en & ~counter_mode
			& (|(stat_view[6:0] & mask));
	end

	// ==========================================
	// Read latch
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata <= 8'h00;
		end else if (rd_start) begin
			unique case (bus_i.addr)
				SCC_ADDR_STATUS: rdata <= {irq_o, stat_view[6:0]};
				SCC_ADDR_CONTROL: rdata <= control_output;
				SCC_ADDR_MASK: rdata <= {1'b0, mask};
				SCC_ADDR_AUX: rdata <= {2'b00, aux_control_word};
			endcase
		end
	end
	assign bus_rdata_o = rdata;

	// ==========================================
	// Mask / period and auxiliary control
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask <= SCC_RST_MASK;
		end else if (wr_mask) begin
			mask <= bus_i.wdata[6:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aux_control_word <= SCC_RST_AUX;
		end else if (wr_aux) begin
			aux_control_word <= bus_i.wdata[5:0];
		end
	end

	// ==========================================
	// Counter
	assign en_eff = counter_run & (~cfg_i.en_used | routed_enable_i);
	assign ld_eff = cfg_i.ld_used & routed_reload_i
		& (cfg_i.ld_indep | en_eff);
	assign tc_comb = counter_value == SCC_TC_COUNT;

	always_comb begin
		next_count = counter_value;
		if (ld_eff) begin
			next_count = counter_period;
		end else if (en_eff) begin
			if (tc_comb) begin
				next_count = counter_period;
			end else begin
				next_count = counter_value - 7'h01;
			end
		end
	end

	// Registered terminal count follows the count it was computed from
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tc_reg <= 1'b0;
		end else if (counter_mode && sc_tick_i) begin
			tc_reg <= next_count == SCC_TC_COUNT;
		end
	end
	assign tc = cfg_i.tc_comb ? tc_comb : tc_reg;

	// ==========================================
	// Control register, shared with the count
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			control_output <= SCC_RST_CONTROL;
		end else if (counter_mode) begin
			if (wr_ctl && !counter_run) begin
				control_output <= {1'b0, bus_i.wdata[6:0]};
			end else if (sc_tick_i) begin
				control_output <= {1'b0, next_count};
			end
		end else if (routed_reset_i && cfg_i.routed_reset_scope) begin
			control_output <= 8'h00;
		end else if (wr_ctl) begin
			control_output <= bus_i.wdata;
		end else begin
			control_output <= control_output & ~pulse_done;
		end
	end

	// ==========================================
	// Per-bit output stages
	generate
		for (genvar g = 0; g < SCC_DW; g++) begin : g_bit
			scc_ctl_stage u_stage (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.sc_tick_i(sc_tick_i),
				.mode_i(scc_ctl_mode_t'({cfg_i.ctrl_bit_mode_high[g],
					cfg_i.ctrl_bit_mode_low[g]})),
				.bit_i(control_output[g]),
				.direct_i(wr_ctl ? bus_i.wdata[g] : control_output[g]),
				.routed_reset_i(routed_reset_i & ~counter_mode),
				.out_o(ctl_out[g]),
				.pulse_done_o(pulse_done[g])
			);
		end
	endgenerate

	always_comb begin
		unique case (cfg_i.sc_output_select)
			SCC_OUT_COUNTER: sc_routing_output_o = {tc, counter_value};
			SCC_OUT_PARALLEL: sc_routing_output_o = dp_parallel_out_i;
			SCC_OUT_CONTROL, SCC_OUT_SPARE: sc_routing_output_o = ctl_out;
		endcase
	end

	// ==========================================
	// Checks
	a_sticky_capture: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		stat_set != 8'h00 |=> (status_capture & $past(stat_set))
		== $past(stat_set))
		else $error("sampled status high was not captured");

	a_sticky_hold: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(!stat_clr_rd && $stable(cfg_i.status_bit_capture_select))
		|=> (status_capture & $past(status_capture))
		== $past(status_capture))
		else $error("sticky status bit dropped without a read");

	a_clear_only_set: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(stat_clr_rd && !sc_tick_i) |=> status_capture == 8'h00)
		else $error("status read did not clear captured bits");

	a_rdata_stable: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(bus_i.sel && bus_i.rd && rd_q) |=> $stable(bus_rdata_o))
		else $error("read data changed during a read access");

	a_irq_masked_or: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(!counter_mode && int_en && (stat_view[6:0] & mask) != 7'h00)
		|-> irq_o)
		else $error("interrupt missing for masked status");

	a_irq_counter_off: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		counter_mode |-> !irq_o)
		else $error("interrupt raised in counter mode");

	a_direct_write: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_ctl && !counter_mode && cfg_i.sc_output_select == SCC_OUT_CONTROL
		&& !cfg_i.ctrl_bit_mode_high[0] && !cfg_i.ctrl_bit_mode_low[0])
		|-> sc_routing_output_o[0] == bus_i.wdata[0])
		else $error("direct write not on routing in write cycle");

	a_count_reload: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && sc_tick_i && en_eff && tc_comb && !wr_ctl)
		|=> counter_value == $past(counter_period))
		else $error("no period reload at terminal count");

	a_load_wins: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && sc_tick_i && ld_eff && !(wr_ctl && !counter_run))
		|=> counter_value == $past(counter_period))
		else $error("routed reload did not load the period");

	a_count_down: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && sc_tick_i && en_eff && !ld_eff && !tc_comb)
		|=> counter_value == $past(counter_value) - 7'h01)
		else $error("counter did not decrement by one");

	a_scope_reset: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(routed_reset_i && cfg_i.routed_reset_scope && !counter_mode)
		|=> control_output == 8'h00)
		else $error("scoped routed reset left control bits");

	a_ctl_readback: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(rd_start && bus_i.addr == SCC_ADDR_CONTROL)
		|=> bus_rdata_o == $past(control_output))
		else $error("control read did not return the stored bits");

	a_pulse_clear: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(!counter_mode && !wr_ctl && !routed_reset_i
		&& pulse_done != 8'h00)
		|=> (control_output & $past(pulse_done)) == 8'h00)
		else $error("pulse bit still set after its pulse");

	a_count_locked: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && counter_run && wr_ctl && !sc_tick_i)
		|=> $stable(counter_value))
		else $error("count written while the counter ran");

	a_run_gates_count: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && !counter_run && !ld_eff && !wr_ctl)
		|=> $stable(counter_value))
		else $error("stopped counter moved without a load");

	a_reload_gated: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && !cfg_i.ld_indep && !en_eff && !wr_ctl)
		|=> $stable(counter_value))
		else $error("routed reload acted without routed enable");

	a_tc_comb: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && cfg_i.tc_comb)
		|-> sc_routing_output_o[7] == (counter_value == SCC_TC_COUNT))
		else $error("combinational terminal count wrong");

	a_period_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(counter_mode && sc_tick_i && counter_period == 7'h00
		&& counter_value == SCC_TC_COUNT) |=> tc_reg)
		else $error("zero period did not give constant terminal count");

	c_status_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		stat_clr_rd && status_capture != 8'h00);
	c_terminal_reload: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		counter_mode && sc_tick_i && en_eff && tc_comb && !ld_eff);
	c_routed_load: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		counter_mode && sc_tick_i && ld_eff && !tc_comb);
endmodule

/* verif/scc_fabric_model.sv */
`timescale 1ns/100ps
module scc_fabric_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests from the bench
	input wire logic tick_en_i,
	input wire logic [7:0] stat_req_i,
	// Routing side
	output logic sc_tick_o,
	output logic [7:0] status_o
);
	logic [1:0] div;

	// ==========================================
	// Status clock enable, one cycle in three
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div <= 2'h0;
			sc_tick_o <= 1'b0;
		end else begin
			div <= (div == 2'h2 || !tick_en_i) ? 2'h0 : div + 2'h1;
			sc_tick_o <= tick_en_i && div == 2'h2;
		end
	end

	// ==========================================
	// Routed status levels, one register late
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			status_o <= 8'h00;
		else
			status_o <= stat_req_i;
	end
endmodule

/* verif/scc_top_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module scc_top_tb;
	import scc_pkg::*;
	logic clk_i, rst_n_i, tick_en, sc_tick, en, ld, rrst, irq;
	scc_bus_t bus;
	scc_cfg_t cfg;
	logic [7:0] rdata, sc_routing_output, stat_req, status_in, r;
	int mismatches, check_count, e, k;

	scc_fabric_model scc_fabric_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tick_en_i(tick_en), .stat_req_i(stat_req), .sc_tick_o(sc_tick),
		.status_o(status_in));
	scc_top scc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sc_tick_i(sc_tick),
		.bus_i(bus), .bus_rdata_o(rdata), .cfg_i(cfg), .status_in_i(status_in),
		.dp_parallel_out_i(8'h3c), .routed_enable_i(en), .routed_reload_i(ld),
		.routed_reset_i(rrst), .sc_routing_output_o(sc_routing_output), .irq_o(irq));

	// ==========================================
	// Bus access and timing helpers
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus <= '{1'b1, 1'b1, 1'b0, a, d};
		@(posedge clk_i);
		bus <= '0;
	endtask

	task rd(input logic [1:0] a, input logic [7:0] x);
		@(posedge clk_i);
		bus <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
		repeat (2) @(posedge clk_i);
		#1 r = rdata;
		`CHK(r, x)
		@(posedge clk_i);
		#1 `CHK(rdata, r)
		@(posedge clk_i);
		bus <= '0;
		@(posedge clk_i);
	endtask

	task tk(input int n);
		repeat (n) begin
			do @(negedge clk_i); while (sc_tick !== 1'b1);
			@(posedge clk_i);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================
	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end

	// ==========================================
	// Test sequence
	initial begin
		rst_n_i = 1'b0;
		bus = '0;
		cfg = '0;
		stat_req = 8'h00;
		{tick_en, en, ld, rrst} = 4'h0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(SCC_ADDR_STATUS, 8'h00);
		rd(SCC_ADDR_CONTROL, 8'h00);
		$display("test reset done");

		@(posedge clk_i);
		bus <= '{1'b1, 1'b1, 1'b0, SCC_ADDR_CONTROL, 8'ha5};
		#1 `CHK(sc_routing_output, 8'ha5)
		@(posedge clk_i);
		bus <= '0;
		rd(SCC_ADDR_CONTROL, 8'ha5);
		cfg.sc_output_select <= SCC_OUT_PARALLEL;
		#1 `CHK(sc_routing_output, 8'h3c)
		@(posedge clk_i);
		cfg.sc_output_select <= SCC_OUT_CONTROL;
		$display("test control done");

		tick_en <= 1'b1;
		cfg.status_bit_capture_select <= 8'h0f;
		stat_req <= 8'h61;
		tk(2);
		stat_req <= 8'h60;
		tk(2);
		rd(SCC_ADDR_STATUS, 8'h61);
		rd(SCC_ADDR_STATUS, 8'h60);
		wr(SCC_ADDR_MASK, 8'h01);
		wr(SCC_ADDR_AUX, 8'h10);
		stat_req <= 8'h01;
		tk(2);
		stat_req <= 8'h00;
		tick_en <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 `CHK(irq, 1'b1)
		rd(SCC_ADDR_STATUS, 8'h81);
		#1 `CHK(irq, 1'b0)
		wr(SCC_ADDR_AUX, 8'h00);
		$display("test status done");

		cfg.ctrl_bit_mode_high <= 8'h02;
		cfg.ctrl_bit_mode_low <= 8'h02;
		wr(SCC_ADDR_CONTROL, 8'h02);
		rd(SCC_ADDR_CONTROL, 8'h02);
		tick_en <= 1'b1;
		k = 0;
		repeat (12) begin
			@(posedge clk_i);
			#1 if (sc_routing_output[1] === 1'b1) k++;
		end
		`CHK(k, 3)
		rd(SCC_ADDR_CONTROL, 8'h00);
		$display("test pulse done");

		for (int s = 0; s < 2; s++) begin
			@(posedge clk_i);
			tick_en <= 1'b0;
			cfg.routed_reset_scope <= s[0];
			cfg.ctrl_bit_mode_high <= 8'h08;
			cfg.ctrl_bit_mode_low <= 8'h04;
			repeat (3) @(posedge clk_i);
			wr(SCC_ADDR_CONTROL, 8'h0c);
			tick_en <= 1'b1;
			tk(1);
			#1 `CHK(sc_routing_output[3:2], 2'b01)
			tk(1);
			#1 `CHK(sc_routing_output[3:2], 2'b11)
			@(posedge clk_i);
			rrst <= 1'b1;
			tk(2);
			#1 `CHK(sc_routing_output[3:2], 2'b00)
			@(posedge clk_i);
			rrst <= 1'b0;
			tick_en <= 1'b0;
			rd(SCC_ADDR_CONTROL, s ? 8'h00 : 8'h0c);
		end
		cfg.ctrl_bit_mode_high <= 8'h00;
		cfg.ctrl_bit_mode_low <= 8'h00;
		$display("test sync done");

		cfg.sc_output_select <= SCC_OUT_COUNTER;
		for (int p = 0; p < 4; p += 3) begin
			@(posedge clk_i);
			tick_en <= 1'b0;
			repeat (3) @(posedge clk_i);
			// The count is only writable while the counter is stopped
			wr(SCC_ADDR_AUX, 8'h00);
			wr(SCC_ADDR_MASK, p[7:0]);
			wr(SCC_ADDR_CONTROL, p[7:0]);
			wr(SCC_ADDR_AUX, 8'h20);
			tick_en <= 1'b1;
			e = p;
			repeat (5) begin
				tk(1);
				e = (e == 0) ? p : e - 1;
				#1 `CHK(sc_routing_output, {e == 0, e[6:0]})
			end
		end
		@(posedge clk_i);
		tick_en <= 1'b0;
		@(posedge clk_i);
		{cfg.ld_used, cfg.ld_indep, ld, tick_en} <= 4'hf;
		tk(2);
		#1 `CHK(sc_routing_output, 8'h03)
		@(posedge clk_i);
		{ld, tick_en} <= 2'b00;
		wr(SCC_ADDR_AUX, 8'h00);
		tick_en <= 1'b1;
		tk(2);
		#1 `CHK(sc_routing_output[6:0], 7'h03)
		wr(SCC_ADDR_CONTROL, 8'h02);
		#1 `CHK(sc_routing_output[6:0], 7'h02)
		// Combinational terminal count, routed enable low, reload gated
		@(posedge clk_i);
		{cfg.tc_comb, cfg.en_used, cfg.ld_indep, ld} <= 4'hd;
		wr(SCC_ADDR_AUX, 8'h20);
		tk(2);
		#1 `CHK(sc_routing_output, 8'h02)
		wr(SCC_ADDR_CONTROL, 8'h05);
		#1 `CHK(sc_routing_output, 8'h02)
		@(posedge clk_i);
		{en, ld} <= 2'b10;
		tk(2);
		#1 `CHK(sc_routing_output, 8'h80)
		$display("test counter done");
		report_and_stop();
	end
endmodule
